// *** design/tci_pkg.sv ***
// package: register map, field positions and timing for the cutoff interlock
package tci_pkg;

	// clock rate
	localparam int unsigned CLK_HZ         = 20000000;

	// timing figures in their own units
	localparam int unsigned GLITCH_TIME_US = 1000;
	localparam int unsigned VALID_TIME_MS  = 500;
	localparam int unsigned RESP_TIME_MS   = 120;

	// derived cycle counts: least times round up, longest round down
	localparam int unsigned GLITCH_CYC =
		(GLITCH_TIME_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int unsigned VALID_CYC  = VALID_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RESP_CYC   = RESP_TIME_MS * (CLK_HZ / 1000);

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_INSTAT  = 8'h04;
	localparam logic [7:0] ADDR_FAULT   = 8'h08;
	localparam logic [7:0] ADDR_IRQSTAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQCLR  = 8'h10;
	localparam logic [7:0] ADDR_IRQEN   = 8'h14;

	// field positions
	localparam int unsigned CTRL_ENABLE_BIT  = 0;
	localparam int unsigned INSTAT_CUT_BIT   = 24;
	localparam int unsigned FAULT_VALID_BIT  = 14;

	// event bits of status, clear and enable registers
	localparam int unsigned EV_W          = 4;
	localparam int unsigned EV_EN_LOW     = 0;
	localparam int unsigned EV_VALID      = 1;
	localparam int unsigned EV_HW_FAULT   = 2;
	localparam int unsigned EV_TRIP       = 3;
	localparam logic [EV_W-1:0] EV_RESET  = 4'h0;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// drive state
	typedef enum logic [1:0] {
		ST_OFF     = 2'h0,
		ST_RUN     = 2'h1,
		ST_BLOCKED = 2'h3
	} drive_state_e;

endpackage : tci_pkg

// *** design/torque_cutoff_interlock.sv ***
// torque cutoff interlock: input filter, validation, alarm and axi-lite regs
`timescale 1ns/1ps
`default_nettype none

module torque_cutoff_interlock
	import tci_pkg::*;
#(
	parameter int unsigned GLITCH_CYCLES = GLITCH_CYC,
	parameter int unsigned VALID_CYCLES  = VALID_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// cutoff input and analog indications
	input  wire logic        torque_cutoff_in_n_i,
	input  wire logic        above_high_i,
	input  wire logic        below_low_i,
	input  wire logic        hw_fault_i,
	// drive outputs
	output logic             gate_supply_en_o,
	output logic             led_o,
	output logic             irq_o,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	// elaboration checks
	if (GLITCH_CYCLES < 1 || GLITCH_CYCLES > RESP_CYC) begin : g_chk_glitch
		$error("glitch filter length out of range");
	end
	if (VALID_CYCLES < 1 || VALID_CYCLES >= (1 << 30)) begin : g_chk_valid
		$error("validation time out of range");
	end

	localparam int unsigned GW = $clog2(GLITCH_CYCLES + 1);
	localparam int unsigned VW = $clog2(VALID_CYCLES + 2);

	// register index decode, used by both bus directions
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == ADDR_CTRL) || (a == ADDR_INSTAT) ||
			(a == ADDR_FAULT) || (a == ADDR_IRQSTAT) ||
			(a == ADDR_IRQCLR) || (a == ADDR_IRQEN);
	endfunction : mapped

	logic              above_s1_q;
	logic              above_s2_q;
	logic              below_s1_q;
	logic              below_s2_q;
	logic              mid_band;
	logic [VW-1:0]     valid_cnt_q;
	logic              valid_err;
	logic [GW-1:0]     low_cnt_q;
	logic              cut_q;
	logic              cut_prev_q;
	logic              en_cmd_q;
	logic              en_prev_q;
	logic              en_rise;
	drive_state_e      state_q;
	logic [EV_W-1:0]   ev_set;
	logic [EV_W-1:0]   ev_stat_q;
	logic [EV_W-1:0]   ev_en_q;
	logic [EV_W-1:0]   ev_clr;
	logic              fault_now;
	logic              alarms_clear;
	logic              aw_have_q;
	logic              w_have_q;
	logic [7:0]        aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              wr_go;
	logic [31:0]       rd_word;

	// comparator synchronisers
	// only the second stage feeds the logic
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			above_s1_q <= 1'b0;
			above_s2_q <= 1'b0;
			below_s1_q <= 1'b0;
			below_s2_q <= 1'b0;
		end else begin
			above_s1_q <= above_high_i;
			above_s2_q <= above_s1_q;
			below_s1_q <= below_low_i;
			below_s2_q <= below_s1_q;
		end
	end

	assign mid_band = !above_s2_q && !below_s2_q;

	// mid-band timer, saturating one past the limit
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			valid_cnt_q <= '0;
		end else if (!mid_band) begin
			valid_cnt_q <= '0;
		end else if (valid_cnt_q <= VW'(VALID_CYCLES)) begin
			valid_cnt_q <= valid_cnt_q + VW'(1);
		end
	end

	assign valid_err = valid_cnt_q > VW'(VALID_CYCLES);

	// low-pulse filter: trip only once low has lasted the full window
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			low_cnt_q <= '0;
			cut_q     <= 1'b1;
		end else if (torque_cutoff_in_n_i) begin
			low_cnt_q <= '0;
			cut_q     <= 1'b0;
		end else if (low_cnt_q < GW'(GLITCH_CYCLES - 1)) begin
			low_cnt_q <= low_cnt_q + GW'(1);
		end else begin
			cut_q     <= 1'b1;
		end
	end

	// enable command edge
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			en_prev_q  <= 1'b0;
			cut_prev_q <= 1'b1;
		end else begin
			en_prev_q  <= en_cmd_q;
			cut_prev_q <= cut_q;
		end
	end

	assign en_rise      = en_cmd_q && !en_prev_q;
	assign fault_now    = hw_fault_i || ev_stat_q[EV_HW_FAULT];
	assign alarms_clear = !ev_stat_q[EV_EN_LOW] && !ev_stat_q[EV_VALID] &&
		!ev_stat_q[EV_HW_FAULT];

	// event sources
	always_comb begin
		ev_set              = EV_RESET;
		ev_set[EV_EN_LOW]   = cut_q && en_cmd_q;
		ev_set[EV_VALID]    = valid_err;
		ev_set[EV_HW_FAULT] = hw_fault_i;
		ev_set[EV_TRIP]     = cut_q && !cut_prev_q;
	end

	// drive state
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= ST_OFF;
		end else begin
			case (state_q)
				ST_OFF: begin
					if (en_rise && !cut_q && alarms_clear && !hw_fault_i) begin
						state_q <= ST_RUN;
					end else if (cut_q || fault_now) begin
						state_q <= ST_BLOCKED;
					end
				end
				ST_RUN: begin
					if (cut_q || fault_now) begin
						state_q <= ST_BLOCKED;
					end else if (!en_cmd_q) begin
						state_q <= ST_OFF;
					end
				end
				ST_BLOCKED: begin
					if (!cut_q && alarms_clear && !hw_fault_i) begin
						state_q <= ST_OFF;
					end
				end
				default: begin
					state_q <= ST_BLOCKED;
				end
			endcase
		end
	end

	// gating from the filtered cutoff input and the fault input, so test pulses keep torque
	assign gate_supply_en_o = (state_q == ST_RUN) &&
		!cut_q &&
		!hw_fault_i;
	assign led_o = !cut_q && !fault_now;
	assign irq_o = |(ev_stat_q & ev_en_q);

	// sticky status: set wins over clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ev_stat_q <= EV_RESET;
		end else begin
			ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
		end
	end

	// axi write channel capture
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// register writes
	always_comb begin
		ev_clr = EV_RESET;
		if (wr_go && aw_addr_q == ADDR_IRQCLR && w_strb_q[0]) begin
			ev_clr = w_data_q[EV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			en_cmd_q <= 1'b0;
			ev_en_q  <= EV_RESET;
		end else if (wr_go && w_strb_q[0]) begin
			if (aw_addr_q == ADDR_CTRL) begin
				en_cmd_q <= w_data_q[CTRL_ENABLE_BIT];
			end
			if (aw_addr_q == ADDR_IRQEN) begin
				ev_en_q <= w_data_q[EV_W-1:0];
			end
		end
	end

	// read mux
	// the clear register is write-only and reads as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			ADDR_CTRL: begin
				rd_word[CTRL_ENABLE_BIT] = en_cmd_q;
			end
			ADDR_INSTAT: begin
				rd_word[INSTAT_CUT_BIT] = !cut_q && !fault_now;
			end
			ADDR_FAULT: begin
				rd_word[FAULT_VALID_BIT] = ev_stat_q[EV_VALID];
			end
			ADDR_IRQSTAT: begin
				rd_word[EV_W-1:0] = ev_stat_q;
			end
			ADDR_IRQCLR: begin
				rd_word = 32'h0000_0000;
			end
			ADDR_IRQEN: begin
				rd_word[EV_W-1:0] = ev_en_q;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// axi read channel
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : torque_cutoff_interlock

`default_nettype wire

// *** tb/tci_props.sv ***
// checker: port-level assertions of the cutoff interlock
`timescale 1ns/1ps
`default_nettype none
module tci_props
	import tci_pkg::*;
#(
	parameter int unsigned GLITCH_CYCLES = GLITCH_CYC,
	parameter int unsigned VALID_CYCLES  = VALID_CYC
) (
	// clock, reset and cutoff side
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic       torque_cutoff_in_n_i,
	input wire logic       hw_fault_i,
	input wire logic       gate_supply_en_o,
	input wire logic       led_o,
	input wire logic       irq_o,
	// bus handshakes
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid
);
	logic [3:0]  wr_age_q;
	logic [31:0] low_run_q;

	// consecutive cycles the cutoff input has been sampled low
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			low_run_q <= 32'h0000_0000;
		end else if (torque_cutoff_in_n_i) begin
			low_run_q <= 32'h0000_0000;
		end else if (low_run_q < GLITCH_CYCLES) begin
			low_run_q <= low_run_q + 32'h0000_0001;
		end
	end

	// cycles since the last accepted write word
	always_ff @(posedge clk_i) begin
		if (srst_i)
			wr_age_q <= 4'hf;
		else if (s_axi_wvalid && s_axi_wready)
			wr_age_q <= 4'h0;
		else if (wr_age_q != 4'hf)
			wr_age_q <= wr_age_q + 4'h1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	chk_low_no_gate: assert property (
		low_run_q >= GLITCH_CYCLES |-> !gate_supply_en_o)
		else $error("gate on after long low input");
	chk_fault_dark: assert property (
		hw_fault_i |-> !gate_supply_en_o && !led_o)
		else $error("gate or led on during fault");
	chk_led_cut_dark: assert property (
		low_run_q >= GLITCH_CYCLES |-> !led_o)
		else $error("led lit after long low");
	chk_glitch_keeps: assert property (
		gate_supply_en_o ##1 (!torque_cutoff_in_n_i && !hw_fault_i) [*6]
		##1 (torque_cutoff_in_n_i && !hw_fault_i) |-> gate_supply_en_o)
		else $error("short pulse dropped torque");
	chk_no_restart: assert property (
		$rose(gate_supply_en_o) && $past(torque_cutoff_in_n_i)
		|-> wr_age_q < 4'h8)
		else $error("torque without fresh enable");
	chk_reset_quiet: assert property (
		$past(srst_i) |-> !gate_supply_en_o && !led_o && !irq_o)
		else $error("outputs active after reset");
	chk_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");

	cover property ($rose(gate_supply_en_o));
	cover property ($rose(irq_o));
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (gate_supply_en_o && !torque_cutoff_in_n_i);
endmodule : tci_props

bind torque_cutoff_interlock tci_props #(
	.GLITCH_CYCLES(GLITCH_CYCLES),
	.VALID_CYCLES(VALID_CYCLES)
) i_props (
	.clk_i(clk_i), .srst_i(srst_i),
	.torque_cutoff_in_n_i(torque_cutoff_in_n_i), .hw_fault_i(hw_fault_i),
	.gate_supply_en_o(gate_supply_en_o), .led_o(led_o), .irq_o(irq_o),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// *** tb/cutoff_source.sv ***
// partner: safety relay driving the cutoff input and comparators
`timescale 1ns/1ps
`default_nettype none
module cutoff_source #(
	parameter int MAX_PULSE = 7
) (
	input  wire logic clk_i,
	input  wire logic cut_i,
	input  wire logic mid_i,
	output logic      pin_n_o,
	output logic      above_o,
	output logic      below_o
);
	logic pulse_q = 1'h0;

	assign pin_n_o = !cut_i && !pulse_q;
	assign above_o = pin_n_o && !mid_i;
	assign below_o = !pin_n_o && !mid_i;

	// self-test low pulse, length capped
	task automatic pulse(input int n);
		@(posedge clk_i);
		pulse_q <= 1'h1;
		repeat ((n > MAX_PULSE) ? MAX_PULSE : n) @(posedge clk_i);
		pulse_q <= 1'h0;
	endtask : pulse
endmodule : cutoff_source
`default_nettype wire

// *** tb/torque_cutoff_interlock_tb.sv ***
// testbench: cutoff interlock scenarios over axi-lite
`timescale 1ns/1ps
`default_nettype none
module torque_cutoff_interlock_tb;
	import tci_pkg::*;
	localparam int G = 8;
	localparam int V = 20;
	logic clk_i = 1'h0, srst_i = 1'h1, cut = 1'h0, mid = 1'h0;
	logic hw_fault_i = 1'h0, torque_cutoff_in_n_i, above_high_i, below_low_i;
	logic gate_supply_en_o, led_o, irq_o, s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	int mismatches = 0, comparisons = 0;

	always #25 clk_i = ~clk_i;

	cutoff_source #(.MAX_PULSE(G - 1)) i_src (.clk_i(clk_i), .cut_i(cut),
		.mid_i(mid), .pin_n_o(torque_cutoff_in_n_i),
		.above_o(above_high_i), .below_o(below_low_i));
	torque_cutoff_interlock #(.GLITCH_CYCLES(G), .VALID_CYCLES(V)) i_dut (
		.clk_i(clk_i), .srst_i(srst_i),
		.torque_cutoff_in_n_i(torque_cutoff_in_n_i),
		.above_high_i(above_high_i), .below_low_i(below_low_i),
		.hw_fault_i(hw_fault_i), .gate_supply_en_o(gate_supply_en_o),
		.led_o(led_o), .irq_o(irq_o),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc

	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : ck

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h1;
		do @(posedge clk_i); while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_i); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge clk_i);
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge clk_i);
	endtask : rd

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic t_run;
		rd(8'h20);
		ck(d, 32'h0);
		ck(rr, RESP_SLVERR);
		wr(8'h20, 32'h1);
		ck(rr, RESP_SLVERR);
		wr(ADDR_CTRL, 32'h1);
		ck(rr, RESP_OKAY);
		cyc(3);
		ck({gate_supply_en_o, led_o}, 2'h3);
		rd(ADDR_INSTAT);
		ck(d[INSTAT_CUT_BIT], 1'h1);
		i_src.pulse(G - 2);
		cyc(2);
		ck(gate_supply_en_o, 1'h1);
		cut <= 1'h1;
		cyc(G);
		ck(gate_supply_en_o, 1'h1);
		cyc(1);
		ck(gate_supply_en_o, 1'h0);
		cyc(G + 4);
		rd(ADDR_INSTAT);
		ck({led_o, d[INSTAT_CUT_BIT]}, 2'h0);
		cut <= 1'h0;
		cyc(G + 2);
		ck(gate_supply_en_o, 1'h0);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQCLR, 32'hf);
		wr(ADDR_CTRL, 32'h1);
		cyc(3);
		ck(gate_supply_en_o, 1'h1);
		wr(ADDR_CTRL, 32'h0);
		$display("run test done");
	endtask : t_run

	task automatic t_idle;
		cut <= 1'h1;
		cyc(G + 4);
		rd(ADDR_IRQSTAT);
		ck(d[2:0], 3'h0);
		wr(ADDR_IRQEN, 32'h1);
		wr(ADDR_CTRL, 32'h1);
		cyc(3);
		rd(ADDR_IRQSTAT);
		ck({gate_supply_en_o, irq_o, d[EV_EN_LOW]}, 3'h3);
		cut <= 1'h0;
		cyc(G + 2);
		ck(gate_supply_en_o, 1'h0);
		rd(ADDR_IRQSTAT);
		ck(d[EV_EN_LOW], 1'h1);
		wr(ADDR_IRQEN, 32'h0);
		ck(irq_o, 1'h0);
		wr(ADDR_IRQEN, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQCLR, 32'hf);
		cyc(1);
		ck(irq_o, 1'h0);
		wr(ADDR_CTRL, 32'h1);
		cyc(3);
		ck(gate_supply_en_o, 1'h1);
		rd(ADDR_IRQSTAT);
		ck(d[2:0], 3'h0);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQEN, 32'h0);
		$display("idle test done");
	endtask : t_idle

	task automatic t_mid;
		mid <= 1'h1;
		cyc(V / 2);
		mid <= 1'h0;
		rd(ADDR_FAULT);
		ck(d[FAULT_VALID_BIT], 1'h0);
		mid <= 1'h1;
		cyc(V + 5);
		mid <= 1'h0;
		rd(ADDR_FAULT);
		ck(d[FAULT_VALID_BIT], 1'h1);
		wr(ADDR_IRQCLR, 32'h2);
		rd(ADDR_FAULT);
		ck(d[FAULT_VALID_BIT], 1'h0);
		$display("mid-band test done");
	endtask : t_mid

	task automatic t_fault;
		wr(ADDR_CTRL, 32'h1);
		cyc(3);
		hw_fault_i <= 1'h1;
		cyc(2);
		rd(ADDR_INSTAT);
		ck({gate_supply_en_o, led_o, d[INSTAT_CUT_BIT]}, 3'h0);
		hw_fault_i <= 1'h0;
		cyc(3);
		ck(gate_supply_en_o, 1'h0);
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_IRQCLR, 32'hf);
		wr(ADDR_CTRL, 32'h1);
		cyc(3);
		ck(gate_supply_en_o, 1'h1);
		$display("fault test done");
	endtask : t_fault

	initial begin
		cyc(20000);
		mismatches++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		cyc(10);
		srst_i <= 1'h0;
		cyc(2);
		t_run();
		t_idle();
		t_mid();
		t_fault();
		conclude();
	end
endmodule : torque_cutoff_interlock_tb
`default_nettype wire
